//--- verilog/sgsw_pkg.sv
// Functional notes
// - Trigger source field: 0 off, 1 command, 2 frequency, 3 droop, 4 speed; default 0.
// - Direction 0 switches at or above threshold; direction 1 at or below.
// - Smoothing mode 0 both ways, 1 skips it going alternate, 2 skips it returning.
// - Threshold is 0 to 65535, default 10, unit set by the chosen source.
// - Smoothing time constant is 0 to 100 ms, default 1 ms.
// - Alternate inertia ratio 0.00 to 300.00, default 7.00, used only in manual mode.
// - Alternate position gain up to 2000.0; below 1.0 the base value is used.
// - Alternate speed gain up to 65535; below 20 the base value is used.
// - Alternate integral compensation up to 5000.0 ms; below 0.1 ms base is used.
// - Alternate vibration frequency up to 300.0 Hz; below 0.1 Hz base is used.
// - Alternate vibration frequency needs manual gain, manual tuning and command source.
// - Alternate position, speed and integral values apply only in manual gain mode.
`default_nettype none
package sgsw_pkg;
  // ----------------------------------------------------------------
  // Register map: byte address is four times the index.
  // ----------------------------------------------------------------
  localparam int         NREG        = 14;
  localparam logic [3:0] IDX_FUNC    = 4'h0;
  localparam logic [3:0] IDX_THR     = 4'h1;
  localparam logic [3:0] IDX_TC      = 4'h2;
  localparam logic [3:0] IDX_INERTIA = 4'h3;
  localparam logic [3:0] IDX_POS     = 4'h4;
  localparam logic [3:0] IDX_SPD     = 4'h5;
  localparam logic [3:0] IDX_INTG    = 4'h6;
  localparam logic [3:0] IDX_VIB     = 4'h7;
  localparam logic [3:0] IDX_MODE    = 4'h8;
  localparam logic [3:0] IDX_BINERT  = 4'h9;
  localparam logic [3:0] IDX_BPOS    = 4'hA;
  localparam logic [3:0] IDX_BSPD    = 4'hB;
  localparam logic [3:0] IDX_BINTG   = 4'hC;
  localparam logic [3:0] IDX_BVIB    = 4'hD;
  localparam logic [3:0] IDX_STATUS  = 4'hE;
  // ----------------------------------------------------------------
  // Field positions, each field four bits wide.
  // ----------------------------------------------------------------
  localparam int SRC_LSB = 0;
  localparam int DIR_LSB = 4;
  localparam int TCD_LSB = 8;
  localparam int GADJ_LSB = 0;
  localparam int VTUNE_LSB = 4;
  // ----------------------------------------------------------------
  // Codes.
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_OFF      = 4'h0;
  localparam logic [3:0] SRC_CMD      = 4'h1;
  localparam logic [3:0] SRC_FREQ     = 4'h2;
  localparam logic [3:0] SRC_DROOP    = 4'h3;
  localparam logic [3:0] SRC_SPEED    = 4'h4;
  localparam logic [3:0] DIR_ABOVE    = 4'h0;
  localparam logic [3:0] DIR_BELOW    = 4'h1;
  localparam logic [3:0] TCD_SWITCH   = 4'h1;
  localparam logic [3:0] TCD_RETURN   = 4'h2;
  localparam logic [3:0] GADJ_MANUAL  = 4'h3;
  localparam logic [3:0] VTUNE_MANUAL = 4'h2;
  // ----------------------------------------------------------------
  // Reset values and upper limits, in the register's own units.
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_VAL [NREG] = '{16'h0000, 16'h000A, 16'h0001, 16'h02BC, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h02BC, 16'h0190, 16'h0320, 16'h012C, 16'h03E8};
  localparam logic [15:0] MAX_VAL [NREG] = '{16'hFFFF, 16'hFFFF, 16'h0064, 16'h7530, 16'h4E20,
    16'hFFFF, 16'hC350, 16'h0BB8, 16'hFFFF, 16'h7530, 16'h4E20, 16'hFFFF, 16'hC350, 16'h0BB8};
  // Floors below which the base value is used (0.1 units except speed).
  localparam logic [15:0] FLOOR_POS  = 16'h000A;
  localparam logic [15:0] FLOOR_SPD  = 16'h0014;
  localparam logic [15:0] FLOOR_INTG = 16'h0001;
  localparam logic [15:0] FLOOR_VIB  = 16'h0001;
  // ----------------------------------------------------------------
  // Timing: eight filter steps per time constant.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int BLEND_SHIFT   = 3;
  localparam int STEP_UNIT_CYC = MS_NS / CLK_PERIOD_NS / (1 << BLEND_SHIFT);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sgsw_pkg
`default_nettype wire

//--- verilog/sgsw_top.sv
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sgsw_top #(
  parameter int P_STEP_UNIT_CYC = sgsw_pkg::STEP_UNIT_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_ctrl_gain_cmd,
  input  wire logic [15:0] i_cmd_freq,
  input  wire logic [15:0] i_droop_pulses,
  input  wire logic [15:0] i_motor_speed,
  output logic [15:0]      o_active_inertia,
  output logic [15:0]      o_active_pos_gain,
  output logic [15:0]      o_active_speed_gain,
  output logic [15:0]      o_active_integral,
  output logic [15:0]      o_active_vib_freq,
  output logic             o_switched,
  output logic             o_blending
);
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ----------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic [1:0] cmd_sync_reg;
  // Reset enters asynchronously but is released through two stages.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  // The command pin comes from the controller, outside this clock.
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cmd_sync_reg <= 2'h0;
    end else begin
      cmd_sync_reg <= {cmd_sync_reg[0], i_ctrl_gain_cmd};
    end
  end
  // ----------------------------------------------------------------
  // Register file and AXI4-Lite slave.
  // ----------------------------------------------------------------
  logic [15:0] reg_file_reg [sgsw_pkg::NREG];
  logic [15:0] reg_file_next [sgsw_pkg::NREG];
  logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [3:0]  waddr_reg, waddr_next;
  logic        wbad_reg, wbad_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        aw_rdy_reg, aw_rdy_next, w_rdy_reg, w_rdy_next, ar_rdy_reg, ar_rdy_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        switched_reg, switched_next;
  logic        blending_reg, blending_next;
  // Address and data are caught independently; the write lands once both are held.
  always_comb begin
    logic [15:0] merged;
    logic [3:0]  ridx;
    merged        = 16'h0000;
    ridx          = i_s_axi_araddr[5:2];
    reg_file_next = reg_file_reg;
    {aw_got_next, w_got_next, wbad_next} = {aw_got_reg, w_got_reg, wbad_reg};
    {bvalid_next, rvalid_next, bresp_next, rresp_next} = {bvalid_reg, rvalid_reg, bresp_reg, rresp_reg};
    {waddr_next, wstrb_next, wdata_next, rdata_next} = {waddr_reg, wstrb_reg, wdata_reg, rdata_reg};
    if (i_s_axi_awvalid && aw_rdy_reg) begin
      aw_got_next = 1'b1;
      waddr_next  = i_s_axi_awaddr[5:2];
      wbad_next   = (i_s_axi_awaddr[7:6] != 2'h0) || (i_s_axi_awaddr[5:2] >= sgsw_pkg::IDX_STATUS);
    end
    if (i_s_axi_wvalid && w_rdy_reg) begin
      w_got_next = 1'b1;
      wdata_next = i_s_axi_wdata;
      wstrb_next = i_s_axi_wstrb;
    end
    if (bvalid_reg && i_s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_got_next && w_got_next && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = wbad_next ? sgsw_pkg::RESP_SLVERR : sgsw_pkg::RESP_OKAY;
      if (!wbad_next) begin
        merged = reg_file_reg[waddr_next];
        if (wstrb_next[0]) begin
          merged[7:0] = wdata_next[7:0];
        end
        if (wstrb_next[1]) begin
          merged[15:8] = wdata_next[15:8];
        end
        // Out-of-range settings are clamped to the top of their range.
        if (merged > sgsw_pkg::MAX_VAL[waddr_next]) begin
          merged = sgsw_pkg::MAX_VAL[waddr_next];
        end
        reg_file_next[waddr_next] = merged;
      end
    end
    if (rvalid_reg && i_s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (i_s_axi_arvalid && ar_rdy_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = sgsw_pkg::RESP_OKAY;
      if (i_s_axi_araddr[7:6] != 2'h0 || ridx > sgsw_pkg::IDX_STATUS) begin
        rresp_next = sgsw_pkg::RESP_SLVERR;
        rdata_next = 32'h0000_0000;
      end else if (ridx == sgsw_pkg::IDX_STATUS) begin
        rdata_next = {30'h0000_0000, blending_reg, switched_reg};
      end else begin
        rdata_next = {16'h0000, reg_file_reg[ridx]};
      end
    end
    aw_rdy_next = !aw_got_next && !bvalid_next;
    w_rdy_next  = !w_got_next && !bvalid_next;
    ar_rdy_next = !rvalid_next;
  end

  // Bus state register.
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_file_reg <= sgsw_pkg::RST_VAL;
      {aw_got_reg, w_got_reg, wbad_reg, aw_rdy_reg, w_rdy_reg, ar_rdy_reg, bvalid_reg, rvalid_reg} <= 8'h00;
      {waddr_reg, wstrb_reg, bresp_reg, rresp_reg} <= 12'h000;
      {wdata_reg, rdata_reg} <= 64'h0000_0000_0000_0000;
    end else begin
      reg_file_reg <= reg_file_next;
      {aw_got_reg, w_got_reg, wbad_reg, aw_rdy_reg, w_rdy_reg, ar_rdy_reg, bvalid_reg, rvalid_reg} <=
        {aw_got_next, w_got_next, wbad_next, aw_rdy_next, w_rdy_next, ar_rdy_next, bvalid_next, rvalid_next};
      {waddr_reg, wstrb_reg, bresp_reg, rresp_reg} <= {waddr_next, wstrb_next, bresp_next, rresp_next};
      {wdata_reg, rdata_reg} <= {wdata_next, rdata_next};
    end
  end

  // ----------------------------------------------------------------
  // Trigger decision and gain targets.
  // ----------------------------------------------------------------
  logic [3:0]  src, dir, tcd, gadj, vtune;
  logic [15:0] thr, qty;
  logic        manual, vib_ok, bypass, tick;
  logic [15:0] target [5];
  logic [23:0] cnt_reg, cnt_next, cnt_lim;

  assign src    = reg_file_reg[sgsw_pkg::IDX_FUNC][sgsw_pkg::SRC_LSB +: 4];
  assign dir    = reg_file_reg[sgsw_pkg::IDX_FUNC][sgsw_pkg::DIR_LSB +: 4];
  assign tcd    = reg_file_reg[sgsw_pkg::IDX_FUNC][sgsw_pkg::TCD_LSB +: 4];
  assign gadj   = reg_file_reg[sgsw_pkg::IDX_MODE][sgsw_pkg::GADJ_LSB +: 4];
  assign vtune  = reg_file_reg[sgsw_pkg::IDX_MODE][sgsw_pkg::VTUNE_LSB +: 4];
  assign thr    = reg_file_reg[sgsw_pkg::IDX_THR];
  assign manual = (gadj == sgsw_pkg::GADJ_MANUAL);
  assign vib_ok = manual && (vtune == sgsw_pkg::VTUNE_MANUAL) && (src == sgsw_pkg::SRC_CMD);

  // Pick the monitored quantity and decide whether the alternate set is wanted.
  always_comb begin
    qty = 16'h0000;
    case (src)
      sgsw_pkg::SRC_FREQ:  qty = i_cmd_freq;
      sgsw_pkg::SRC_DROOP: qty = i_droop_pulses;
      sgsw_pkg::SRC_SPEED: qty = i_motor_speed;
      default:             qty = 16'h0000;
    endcase
    switched_next = 1'b0;
    if (src == sgsw_pkg::SRC_CMD) begin
      switched_next = cmd_sync_reg[1];
    end else if (src == sgsw_pkg::SRC_FREQ || src == sgsw_pkg::SRC_DROOP || src == sgsw_pkg::SRC_SPEED) begin
      switched_next = (dir == sgsw_pkg::DIR_BELOW) ? (qty <= thr) : (qty >= thr);
    end
  end

  // Targets: alternate only while switched, enabled by mode, and at or above any floor.
  always_comb begin
    target[0] = (switched_reg && manual) ? reg_file_reg[sgsw_pkg::IDX_INERTIA]
                                         : reg_file_reg[sgsw_pkg::IDX_BINERT];
    target[1] = (switched_reg && manual && reg_file_reg[sgsw_pkg::IDX_POS] >= sgsw_pkg::FLOOR_POS)
              ? reg_file_reg[sgsw_pkg::IDX_POS] : reg_file_reg[sgsw_pkg::IDX_BPOS];
    target[2] = (switched_reg && manual && reg_file_reg[sgsw_pkg::IDX_SPD] >= sgsw_pkg::FLOOR_SPD)
              ? reg_file_reg[sgsw_pkg::IDX_SPD] : reg_file_reg[sgsw_pkg::IDX_BSPD];
    target[3] = (switched_reg && manual && reg_file_reg[sgsw_pkg::IDX_INTG] >= sgsw_pkg::FLOOR_INTG)
              ? reg_file_reg[sgsw_pkg::IDX_INTG] : reg_file_reg[sgsw_pkg::IDX_BINTG];
    target[4] = (switched_reg && vib_ok && reg_file_reg[sgsw_pkg::IDX_VIB] >= sgsw_pkg::FLOOR_VIB)
              ? reg_file_reg[sgsw_pkg::IDX_VIB] : reg_file_reg[sgsw_pkg::IDX_BVIB];
  end

  // ----------------------------------------------------------------
  // First-order blend toward the targets.
  // ----------------------------------------------------------------
  // A zero constant, or the disabled direction, jumps straight to the target.
  assign bypass = (reg_file_reg[sgsw_pkg::IDX_TC] == 16'h0000)
               || (tcd == sgsw_pkg::TCD_SWITCH && switched_reg)
               || (tcd == sgsw_pkg::TCD_RETURN && !switched_reg);
  assign cnt_lim = 24'(reg_file_reg[sgsw_pkg::IDX_TC]) * 24'(P_STEP_UNIT_CYC);
  assign tick    = (cnt_reg + 24'h000001 >= cnt_lim);
  assign cnt_next = tick ? 24'h000000 : cnt_reg + 24'h000001;

  logic [15:0]        active_reg [5];
  logic [15:0]        active_next [5];
  logic signed [16:0] diff [5];
  logic signed [16:0] step [5];
  logic [4:0]         moving;

  // Each step closes one eighth of the gap, so eight steps span one constant.
  for (genvar g = 0; g < 5; g++) begin : g_blend
    always_comb begin
      diff[g]        = $signed({1'b0, target[g]}) - $signed({1'b0, active_reg[g]});
      step[g]        = diff[g] >>> sgsw_pkg::BLEND_SHIFT;
      moving[g]      = (diff[g] != 17'sh00000);
      active_next[g] = active_reg[g];
      if (bypass || (tick && step[g] == 17'sh00000)) begin
        active_next[g] = target[g];
      end else if (tick) begin
        active_next[g] = 16'(active_reg[g] + step[g][15:0]);
      end
    end
  end
  // Any gap left between an active value and its target keeps the flag up.
  assign blending_next = (moving != 5'h00);
  // Blend and trigger state register.
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      active_reg   <= '{sgsw_pkg::RST_VAL[9], sgsw_pkg::RST_VAL[10], sgsw_pkg::RST_VAL[11],
                        sgsw_pkg::RST_VAL[12], sgsw_pkg::RST_VAL[13]};
      cnt_reg      <= 24'h000000;
      switched_reg <= 1'b0;
      blending_reg <= 1'b0;
    end else begin
      active_reg   <= active_next;
      cnt_reg      <= cnt_next;
      switched_reg <= switched_next;
      blending_reg <= blending_next;
    end
  end
  // Outputs come straight from their flip-flops.
  assign o_active_inertia    = active_reg[0];
  assign o_active_pos_gain   = active_reg[1];
  assign o_active_speed_gain = active_reg[2];
  assign o_active_integral   = active_reg[3];
  assign o_active_vib_freq   = active_reg[4];
  assign o_switched          = switched_reg;
  assign o_blending          = blending_reg;
  assign o_s_axi_awready     = aw_rdy_reg;
  assign o_s_axi_wready      = w_rdy_reg;
  assign o_s_axi_bvalid      = bvalid_reg;
  assign o_s_axi_bresp       = bresp_reg;
  assign o_s_axi_arready     = ar_rdy_reg;
  assign o_s_axi_rvalid      = rvalid_reg;
  assign o_s_axi_rresp       = rresp_reg;
  assign o_s_axi_rdata       = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_sync_reg);
  sequence s_fast_switch;
    $rose(switched_reg) && (tcd == sgsw_pkg::TCD_SWITCH);
  endsequence
  sequence s_fast_return;
    $fell(switched_reg) && (tcd == sgsw_pkg::TCD_RETURN);
  endsequence
  property p_off_never;
    (src == sgsw_pkg::SRC_OFF) |=> !switched_reg;
  endproperty
  a_off_never: assert property (p_off_never) else $error("Switched with trigger disabled.");
  property p_above;
    (src == sgsw_pkg::SRC_SPEED && dir == sgsw_pkg::DIR_ABOVE && i_motor_speed >= thr) |=> switched_reg;
  endproperty
  a_above: assert property (p_above) else $error("Speed at threshold did not switch.");
  property p_below;
    (src == sgsw_pkg::SRC_DROOP && dir == sgsw_pkg::DIR_BELOW && i_droop_pulses > thr) |=> !switched_reg;
  endproperty
  a_below: assert property (p_below) else $error("Droop above threshold switched.");
  property p_fast_edge;
    (s_fast_switch or s_fast_return) |=> (active_reg[1] == $past(target[1]));
  endproperty
  a_fast_edge: assert property (p_fast_edge) else $error("Bypassed edge was smoothed.");
  property p_tc_zero;
    (reg_file_reg[sgsw_pkg::IDX_TC] == 16'h0000) |=> (active_reg[2] == $past(target[2]));
  endproperty
  a_tc_zero: assert property (p_tc_zero) else $error("Zero constant did not jump.");
  property p_inertia;
    !manual |-> (target[0] == reg_file_reg[sgsw_pkg::IDX_BINERT]);
  endproperty
  a_inertia: assert property (p_inertia) else $error("Alternate inertia outside manual mode.");
  property p_pos_floor;
    (reg_file_reg[sgsw_pkg::IDX_POS] < sgsw_pkg::FLOOR_POS) |-> (target[1] == reg_file_reg[sgsw_pkg::IDX_BPOS]);
  endproperty
  a_pos_floor: assert property (p_pos_floor) else $error("Position gain below floor used.");
  property p_spd_floor;
    (reg_file_reg[sgsw_pkg::IDX_SPD] < sgsw_pkg::FLOOR_SPD) |-> (target[2] == reg_file_reg[sgsw_pkg::IDX_BSPD]);
  endproperty
  a_spd_floor: assert property (p_spd_floor) else $error("Speed gain below floor used.");
  property p_intg_floor;
    (reg_file_reg[sgsw_pkg::IDX_INTG] == 16'h0000) |-> (target[3] == reg_file_reg[sgsw_pkg::IDX_BINTG]);
  endproperty
  a_intg_floor: assert property (p_intg_floor) else $error("Integral below floor used.");
  property p_vib_floor;
    (reg_file_reg[sgsw_pkg::IDX_VIB] == 16'h0000) |-> (target[4] == reg_file_reg[sgsw_pkg::IDX_BVIB]);
  endproperty
  a_vib_floor: assert property (p_vib_floor) else $error("Vibration below floor used.");
  property p_vib_cond;
    (src != sgsw_pkg::SRC_CMD || vtune != sgsw_pkg::VTUNE_MANUAL) |-> (target[4] == reg_file_reg[sgsw_pkg::IDX_BVIB]);
  endproperty
  a_vib_cond: assert property (p_vib_cond) else $error("Alternate vibration without conditions.");
  property p_manual;
    (switched_reg && !manual) |-> (target[2] == reg_file_reg[sgsw_pkg::IDX_BSPD]);
  endproperty
  a_manual: assert property (p_manual) else $error("Alternate speed gain outside manual mode.");
  property p_blend;
    (tick && !bypass && (diff[2] >= 17'sh00008 || diff[2] <= -17'sh00008)) |=> (active_reg[2] != $past(active_reg[2]));
  endproperty
  a_blend: assert property (p_blend) else $error("Blend step did not move.");

endmodule : sgsw_top
`default_nettype wire

//--- sim/sgsw_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sgsw_ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_cmd_req,
  input  wire logic [15:0] i_qty_req,
  output logic             o_gain_cmd,
  output logic [15:0]      o_qty
);
  // A gain request made while moving waits for standstill, avoiding a shock.
  always_ff @(posedge i_clk) begin
    o_qty <= i_qty_req;
    if (o_qty == 16'h0000) o_gain_cmd <= i_cmd_req;
  end
endmodule : sgsw_ctrl_model
`default_nettype wire

//--- sim/servo_gain_switching_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module servo_gain_switching_logic_tb_top;
  logic        clk, rstn, awv, wv, bry, arv, rry, cmd_req, awr, wr, bv, arr, rv, gcmd, sw, bl;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, seed;
  logic [1:0]  br, rr;
  logic [15:0] qreq, qty, a_in, a_pos, a_spd, a_int, a_vib;
  logic [33:0] exq[$];
  int          bad_count, total_checks, cyc;
  // ---------------------------------------------
  // Clock, partner and design.
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  sgsw_ctrl_model ctl_u (.i_clk(clk), .i_cmd_req(cmd_req), .i_qty_req(qreq), .o_gain_cmd(gcmd), .o_qty(qty));
  sgsw_top #(.P_STEP_UNIT_CYC(2)) dut_u (.i_clk(clk), .i_rstn(rstn), .i_s_axi_awaddr(awa),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .i_ctrl_gain_cmd(gcmd), .i_cmd_freq(qty), .i_droop_pulses(qty), .i_motor_speed(qty),
    .o_active_inertia(a_in), .o_active_pos_gain(a_pos), .o_active_speed_gain(a_spd),
    .o_active_integral(a_int), .o_active_vib_freq(a_vib), .o_switched(sw), .o_blending(bl));
  // ---------------------------------------------
  // Helpers.
  // ---------------------------------------------
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Write address and data go out together; each drops when its ready is seen.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    exq.push_back({e, 32'h0});
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    exq.push_back(e);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
  endtask : axr
  task automatic wreg(input logic [3:0] i, input logic [31:0] d);
    axw({2'b00, i, 2'b00}, d, sgsw_pkg::RESP_OKAY);
  endtask : wreg
  // Each finished bus answer is matched against the oldest note.
  always @(posedge clk) begin
    if (bv && bry) chk("bresp", exq.pop_front(), {br, 32'h0});
    if (rv && rry) chk("read", exq.pop_front(), {rr, rd});
  end
  // A stuck handshake must not hang the run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // ---------------------------------------------
  // Scenarios.
  // ---------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] q;
    int          n;
    seed = 32'h00017AD4; rstn = 1'b0; awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0; rry = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; qreq = 16'h0000; cmd_req = 1'b0;
    wt(6);
    rstn <= 1'b1;
    wt(4);
    for (int i = 0; i < 14; i++) axr({2'b00, 4'(i), 2'b00}, {18'h0, sgsw_pkg::RST_VAL[i]});
    axr(8'h3C, {sgsw_pkg::RESP_SLVERR, 32'h0});
    axr(8'h38, {sgsw_pkg::RESP_OKAY, 32'h0});
    axw(8'h38, 32'h1, sgsw_pkg::RESP_SLVERR);
    wreg(sgsw_pkg::IDX_TC, 32'hC8);
    axr(8'h08, 34'h64);
    wreg(sgsw_pkg::IDX_THR, 32'hFFFF);
    axr(8'h04, 34'hFFFF);
    $display("test registers done");
    wreg(sgsw_pkg::IDX_TC, 32'h0);
    for (int k = 0; k < 14; k++) begin
      r = xorshift();
      q = (k % 4 == 0) ? r[15:0] : r[31:16];
      wreg(sgsw_pkg::IDX_FUNC, {23'h0, r[0], sgsw_pkg::SRC_FREQ + 4'(k % 3)});
      wreg(sgsw_pkg::IDX_THR, {16'h0, r[15:0]});
      qreq <= (k > 11) ? 16'hFFFF : q;
      if (k > 11) wreg(sgsw_pkg::IDX_FUNC, 32'(k == 12 ? sgsw_pkg::SRC_OFF : 4'h5));
      wt(4);
      chk("switched", (k < 12) && (r[0] ? q <= r[15:0] : q >= r[15:0]), sw);
    end
    $display("test trigger done");
    qreq <= 16'h0000;
    wreg(sgsw_pkg::IDX_MODE, 32'h23);
    wreg(sgsw_pkg::IDX_POS, 32'h5);
    wreg(sgsw_pkg::IDX_SPD, 32'h64);
    wreg(sgsw_pkg::IDX_VIB, 32'h32);
    wreg(sgsw_pkg::IDX_INERTIA, 32'h4D2);
    wreg(sgsw_pkg::IDX_FUNC, 32'(sgsw_pkg::SRC_CMD));
    cmd_req <= 1'b1;
    wt(8);
    chk("pos", 34'h190, a_pos);
    chk("spd", 34'h64, a_spd);
    chk("intg", 34'h12C, a_int);
    chk("vib", 34'h32, a_vib);
    chk("inertia", 34'h4D2, a_in);
    axr(8'h38, {sgsw_pkg::RESP_OKAY, 32'h1});
    wreg(sgsw_pkg::IDX_MODE, 32'h03);
    wt(3);
    chk("vib", 34'h3E8, a_vib);
    wreg(sgsw_pkg::IDX_MODE, 32'h20);
    wt(3);
    chk("spd", 34'h320, a_spd);
    chk("inertia", 34'h2BC, a_in);
    $display("test gains done");
    wreg(sgsw_pkg::IDX_MODE, 32'h23);
    wreg(sgsw_pkg::IDX_TC, 32'h1);
    cmd_req <= 1'b0;
    wt(10);
    chk("mid", 34'h1, {33'h0, a_spd > 16'h0064 && a_spd < 16'h0320});
    n = 0;
    while (bl !== 1'b0 && n < 400) begin
      wt(1);
      n++;
    end
    chk("settle", 34'h1, {33'h0, n < 400});
    chk("spd", 34'h320, a_spd);
    $display("test blend done");
    for (int m = 1; m < 3; m++) begin
      wreg(sgsw_pkg::IDX_FUNC, {20'h0, 4'(m), 8'h01});
      wreg(sgsw_pkg::IDX_TC, 32'h64);
      cmd_req <= 1'b1;
      wt(8);
      chk("blend", 34'(m == 2), bl);
      chk("direct", 34'(m == 1), {33'h0, a_spd === 16'h0064});
      wreg(sgsw_pkg::IDX_TC, 32'h0);
      wt(3);
      wreg(sgsw_pkg::IDX_TC, 32'h64);
      cmd_req <= 1'b0;
      wt(8);
      chk("blend", 34'(m == 1), bl);
      wreg(sgsw_pkg::IDX_TC, 32'h0);
      wt(3);
    end
    $display("test bypass done");
    conclude();
  end
endmodule : servo_gain_switching_logic_tb_top
`default_nettype wire
